//--- design/sdspi_in_filt.sv
// two-flop synchroniser and short pulse filter for each serial input
`timescale 1ns/1ps
module sdspi_in_filt
   import sdspi_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // pin bundle
   sdspi_in_if.filt pins
);
   genvar g;
   generate
      for (g = 0; g < IN_N; g++) begin : g_bit
         logic m_q;       // first synchroniser stage
         logic s_q;       // second synchroniser stage
         logic out_q;     // accepted level
         logic [1:0] cnt_q; // samples the new level has held

         // synchroniser, first stage read only by the second
         always_ff @(posedge i_core_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               m_q <= PIN_RST[g];
               s_q <= PIN_RST[g];
            end else begin
               m_q <= pins.raw[g];
               s_q <= m_q;
            end
         end

         always_ff @(posedge i_core_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               out_q <= PIN_RST[g];
               cnt_q <= 2'h0;
            end else if (s_q == out_q) begin
               // level agrees, restart the count
               cnt_q <= 2'h0;
            end else if (cnt_q == FILT_CYC) begin
               // new level held long enough
               out_q <= s_q;
               cnt_q <= 2'h0;
            end else begin
               cnt_q <= cnt_q + 2'h1;
            end
         end

         assign pins.clean[g] = out_q;

         // a level seen in one sample only never reaches the output
         sequence s_blip;
            (s_q != out_q) && (cnt_q == 2'h0) ##1 (s_q == out_q);
         endsequence
         property p_filt_blip;
            @(posedge i_core_clk) disable iff (!i_nrst)
            s_blip |=> $stable(out_q);
         endproperty
         a_filt_blip: assert property (p_filt_blip)
            else $error("filtered input followed a one-sample pulse");
      end
   endgenerate
endmodule

//--- design/sdspi_in_if.sv
// bundle of raw and filtered serial pins between the port and its filter
`timescale 1ns/1ps
interface sdspi_in_if;
   import sdspi_pkg::*;
   logic [IN_N-1:0] raw;   // pin levels as they arrive
   logic [IN_N-1:0] clean; // synchronised and glitch filtered levels
   modport filt (input raw, output clean);
   modport core (output raw, input clean);
endinterface

//--- design/sdspi_pkg.sv
// constants and types shared by the serial slave port of the motor driver
package sdspi_pkg;
   // core clock period and glitch filter figure
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned FILT_NS = 20;
   // least filter time rounds up to whole cycles, never below one
   localparam int unsigned FILT_CYC_I = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] FILT_CYC = (FILT_CYC_I < 1) ? 2'h1 : 2'(FILT_CYC_I);
   // command word layout
   localparam int unsigned WORD_W = 20;
   localparam int unsigned ADDR_HI = 19;
   localparam int unsigned ADDR_MID = 18;
   localparam int unsigned ADDR_LO = 17;
   localparam int unsigned RSEL_HI = 5;
   localparam int unsigned RSEL_LO = 4;
   localparam logic [4:0] BITS_FULL = 5'h14;
   // input pin index inside the filter bundle
   localparam int unsigned IN_SCK = 0;
   localparam int unsigned IN_SDI = 1;
   localparam int unsigned IN_CSN = 2;
   localparam int unsigned IN_DIS = 3;
   localparam int unsigned IN_N = 4;
   // idle levels of the pins: clock high, select high, data low
   localparam logic [3:0] PIN_RST = 4'h5;
   // reset values
   localparam logic [1:0] RSEL_RST = 2'h0;
   localparam logic [19:0] WORD_RST = 20'h00000;
   localparam logic [4:0] CNT_RST = 5'h00;
   // response select codes and fixed marker bits
   localparam logic [1:0] RSEL_MSTEP = 2'h0;
   localparam logic [1:0] RSEL_LOAD = 2'h1;
   localparam logic [1:0] RSEL_LOAD_SCALE = 2'h2;
   localparam logic [1:0] RSEL_PROT = 2'h3;
   localparam logic [1:0] MARK_DATA = 2'h0;
   localparam logic [1:0] MARK_PROT = 2'h3;
   // register that a command word writes
   typedef enum logic [2:0] {
      TGT_DRV_CTRL,
      TGT_CHOP_CFG,
      TGT_ENERGY_CFG,
      TGT_STALL_CFG,
      TGT_DRV_CFG
   } sdspi_target_e;
   // link state
   typedef enum logic {
      ST_IDLE,
      ST_SHIFT
   } sdspi_state_e;
endpackage

//--- design/sdspi_slave.sv
// serial slave port of the motor driver: shift, latch, decode, respond
`timescale 1ns/1ps
module sdspi_slave
   import sdspi_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // serial bus pins
   input wire logic i_sck,
   input wire logic i_sdi,
   input wire logic i_chip_select_low_n,
   output logic o_sdo,
   output logic o_sdo_oe,
   // driver disable pin and its filtered level
   input wire logic i_driver_disable_input,
   output logic o_driver_disable,
   // status sources
   input wire logic [9:0] i_stat_mstep,
   input wire logic [9:0] i_stat_load,
   input wire logic [4:0] i_stat_scale,
   input wire logic [8:0] i_stat_prot,
   input wire logic [7:0] i_stat_flags,
   // command output
   output logic o_cmd_strobe,
   output logic [19:0] o_cmd_word,
   output sdspi_target_e o_cmd_target,
   output logic [1:0] o_response_format_select
);
   // pin bundle and filter
   sdspi_in_if pins ();
   logic sck_f;       // filtered bus clock
   logic sdi_f;       // filtered serial input
   logic csn_f;       // filtered select, low active
   logic sck_prev_q;  // bus clock one cycle ago
   logic csn_prev_q;  // select one cycle ago
   logic sck_rise;    // rising bus clock seen
   logic sck_fall;    // falling bus clock seen
   logic csn_fall;    // select asserted
   logic csn_rise;    // select released
   sdspi_state_e state_q; // link state
   logic [19:0] shift_q;  // twenty-stage shift register
   logic [4:0] cnt_q;     // bits taken, saturates at twenty
   logic sdo_q;           // serial output level
   logic [19:0] resp_word; // status word to return
   sdspi_target_e tgt_d;   // decoded target of the shift word
   logic [1:0] rsel_q;     // response format select

   // route the pins into the filter
   assign pins.raw[IN_SCK] = i_sck;
   assign pins.raw[IN_SDI] = i_sdi;
   assign pins.raw[IN_CSN] = i_chip_select_low_n;
   assign pins.raw[IN_DIS] = i_driver_disable_input;

   sdspi_in_filt u_filt (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .pins       (pins.filt)
   );

   assign sck_f = pins.clean[IN_SCK];
   assign sdi_f = pins.clean[IN_SDI];
   assign csn_f = pins.clean[IN_CSN];
   assign o_driver_disable = pins.clean[IN_DIS];

   // previous levels for edge finding
   // clock idles high
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sck_prev_q <= PIN_RST[IN_SCK];
         csn_prev_q <= PIN_RST[IN_CSN];
      end else begin
         sck_prev_q <= sck_f;
         csn_prev_q <= csn_f;
      end
   end

   // edge pulses of the filtered signals
   assign sck_rise = sck_f & ~sck_prev_q;
   assign sck_fall = ~sck_f & sck_prev_q;
   assign csn_fall = ~csn_f & csn_prev_q;
   assign csn_rise = csn_f & ~csn_prev_q;

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               // select asserted opens a transaction
               if (csn_fall) begin
                  state_q <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               // select released closes it
               if (csn_rise) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_comb begin
      unique case (rsel_q)
         RSEL_MSTEP: resp_word = {i_stat_mstep, MARK_DATA, i_stat_flags};
         RSEL_LOAD: resp_word = {i_stat_load, MARK_DATA, i_stat_flags};
         RSEL_LOAD_SCALE: resp_word = {i_stat_load[9:5], i_stat_scale, MARK_DATA,
                                       i_stat_flags};
         RSEL_PROT: resp_word = {i_stat_prot[8], o_driver_disable, i_stat_prot[7:0],
                                 MARK_PROT, i_stat_flags};
      endcase
   end

   // shift register: load status, then shift msb first
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         shift_q <= WORD_RST;
      end else if (state_q == ST_IDLE) begin
         if (csn_fall) begin
            shift_q <= resp_word;
         end
      end else if (sck_rise) begin
         shift_q <= {shift_q[WORD_W-2:0], sdi_f};
      end
   end

   // bits taken in this transaction
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q <= CNT_RST;
      end else if (csn_fall) begin
         // new transaction starts from zero
         cnt_q <= CNT_RST;
      end else if (state_q == ST_SHIFT && sck_rise && cnt_q != BITS_FULL) begin
         cnt_q <= cnt_q + 5'h01;
      end
   end

   // serial output level
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sdo_q <= 1'b0;
      end else if (state_q == ST_IDLE) begin
         // first status bit on select fall
         if (csn_fall) begin
            sdo_q <= resp_word[WORD_W-1];
         end
      end else if (sck_fall) begin
         sdo_q <= shift_q[WORD_W-1];
      end
   end

   assign o_sdo = sdo_q;
   // output driven only while selected
   assign o_sdo_oe = (state_q == ST_SHIFT);

   always_comb begin
      tgt_d = TGT_DRV_CTRL;
      if (shift_q[ADDR_HI]) begin
         unique case ({shift_q[ADDR_MID], shift_q[ADDR_LO]})
            2'h0: tgt_d = TGT_CHOP_CFG;
            2'h1: tgt_d = TGT_ENERGY_CFG;
            2'h2: tgt_d = TGT_STALL_CFG;
            2'h3: tgt_d = TGT_DRV_CFG;
         endcase
      end
   end

   // command latch on select release
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cmd_strobe <= 1'b0;
         o_cmd_word <= WORD_RST;
         o_cmd_target <= TGT_DRV_CTRL;
      end else if (state_q == ST_SHIFT && csn_rise && cnt_q == BITS_FULL) begin
         // whole words only reach the core
         o_cmd_strobe <= 1'b1;
         o_cmd_word <= shift_q;
         o_cmd_target <= tgt_d;
      end else begin
         o_cmd_strobe <= 1'b0;
      end
   end

   // format select lives in the driver configuration word
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rsel_q <= RSEL_RST;
      end else if (o_cmd_strobe && o_cmd_target == TGT_DRV_CFG) begin
         rsel_q <= o_cmd_word[RSEL_HI:RSEL_LO];
      end
   end

   assign o_response_format_select = rsel_q;

   // checks on the port behaviour
   // shift register holds still outside a transaction
   property p_idle_quiet;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (state_q == ST_IDLE && !csn_fall) |=> $stable(shift_q);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("shift register moved while deselected");

   // rising clock takes the filtered data bit
   property p_rise_sample;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (state_q == ST_SHIFT && sck_rise) |=>
         shift_q == {$past(shift_q[18:0]), $past(sdi_f)};
   endproperty
   a_rise_sample: assert property (p_rise_sample)
      else $error("data bit not shifted in on rising clock");

   // falling clock puts the top stage on the output
   property p_fall_drive;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (state_q == ST_SHIFT && sck_fall) |=> o_sdo == $past(shift_q[19]);
   endproperty
   a_fall_drive: assert property (p_fall_drive)
      else $error("output not updated after falling clock");

   // output stays put between falling edges
   property p_sdo_hold;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (state_q == ST_SHIFT && !sck_fall) |=> $stable(o_sdo);
   endproperty
   a_sdo_hold: assert property (p_sdo_hold)
      else $error("output changed without a falling clock");

   // select fall loads the status word, msb on the pin
   property p_load_msb;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (state_q == ST_IDLE && csn_fall) |=>
         (o_sdo == $past(resp_word[19])) && (shift_q == $past(resp_word)) && o_sdo_oe;
   endproperty
   a_load_msb: assert property (p_load_msb)
      else $error("status word not loaded msb first at select fall");

   // full word then release gives one command with that word
   sequence s_full_release;
      (state_q == ST_SHIFT && cnt_q == BITS_FULL && csn_rise);
   endsequence
   property p_latch;
      @(posedge i_core_clk) disable iff (!i_nrst)
      s_full_release |=> o_cmd_strobe && (o_cmd_word == $past(shift_q)) ##1 !o_cmd_strobe;
   endproperty
   a_latch: assert property (p_latch)
      else $error("command not latched on select release");

   // a short word never produces a command
   property p_short_drop;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (csn_rise && cnt_q != BITS_FULL) |=> !o_cmd_strobe;
   endproperty
   a_short_drop: assert property (p_short_drop)
      else $error("partial word issued as command");

   // target follows the top address bits
   property p_decode;
      @(posedge i_core_clk) disable iff (!i_nrst)
      o_cmd_strobe |-> (o_cmd_word[19] == (o_cmd_target != TGT_DRV_CTRL)) &&
         ((o_cmd_target == TGT_DRV_CFG) == (o_cmd_word[19:17] == 3'h7));
   endproperty
   a_decode: assert property (p_decode)
      else $error("command target does not match address bits");

   // driver configuration write sets the format select
   property p_rsel;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (o_cmd_strobe && o_cmd_target == TGT_DRV_CFG) |=>
         o_response_format_select == $past(o_cmd_word[5:4]);
   endproperty
   a_rsel: assert property (p_rsel)
      else $error("format select not taken from configuration word");
endmodule

//--- tb/sdspi_host.sv
// host model: serial bus master in clock mode 3
`timescale 1ns/1ps
module sdspi_host (
   // bus pins driven by the master
   output logic o_sck,
   output logic o_sdi,
   output logic o_chip_select_low_n,
   // slave answer
   input wire logic i_sdo,
   input wire logic i_sdo_oe
);
   localparam time HALF = 400;
   int oe_miss = 0; // answer samples taken while the output was off
   // idle with clock high and select high
   initial begin
      o_sck = 1'b1;
      o_sdi = 1'b0;
      o_chip_select_low_n = 1'b1;
   end
   // one framed transfer of n bits, answer collected msb first
   task automatic xfer(input int n, input logic [63:0] data, output logic [63:0] got);
      got = '0;
      // select held low for the whole frame
      o_chip_select_low_n = 1'b0;
      #(2 * HALF);
      for (int k = n - 1; k >= 0; k--) begin
         // data changes with the falling clock
         o_sck = 1'b0;
         o_sdi = data[k];
         #HALF;
         o_sck = 1'b1;
         #HALF;
         // answer to this clock has settled by the end of its high phase
         // an undriven line reads back inverted so a late enable shows
         got[k] = i_sdo_oe ? i_sdo : ~i_sdo;
         if (i_sdo_oe !== 1'b1) begin
            oe_miss++;
         end
      end
      // clock stays high well before select rises
      #HALF;
      o_chip_select_low_n = 1'b1;
      // released data line must not keep its last value
      o_sdi = ~o_sdi;
      #(2 * HALF);
   endtask
   // clock and data activity while deselected
   task automatic noise(input int n);
      for (int k = 0; k < n; k++) begin
         o_sck = 1'b0;
         o_sdi = ~o_sdi;
         #HALF;
         o_sck = 1'b1;
         #HALF;
      end
   endtask
   // select pulse far shorter than the filter passes
   task automatic csn_glitch();
      o_chip_select_low_n = 1'b0;
      #15;
      o_chip_select_low_n = 1'b1;
   endtask
endmodule

//--- tb/stepper_driver_spi_slave_bench.sv
// self-checking bench of the serial slave port
`timescale 1ns/1ps
module stepper_driver_spi_slave_bench;
   import sdspi_pkg::*;
   logic i_core_clk, i_nrst, sck, sdi, csn_n, dis;
   logic [9:0] mstep, load;
   logic [4:0] scale;
   logic [8:0] prot;
   logic [7:0] flags;
   logic o_sdo, o_sdo_oe, o_driver_disable, o_cmd_strobe;
   logic [19:0] o_cmd_word, last_w, mon_w;
   logic [1:0] o_response_format_select, cur_sel;
   sdspi_target_e o_cmd_target;
   logic [63:0] cfg;
   logic [31:0] rng = 32'h0E07931B;
   logic [19:0] exp_q[$]; // command words still awaited
   int err_count = 0;
   int samples_checked = 0;
   // core clock of 10 MHz
   initial begin
      i_core_clk = 1'b0;
      forever #50 i_core_clk = ~i_core_clk;
   end
   sdspi_slave u_dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_sck(sck), .i_sdi(sdi),
      .i_chip_select_low_n(csn_n), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
      .i_driver_disable_input(dis), .o_driver_disable(o_driver_disable),
      .i_stat_mstep(mstep), .i_stat_load(load), .i_stat_scale(scale), .i_stat_prot(prot),
      .i_stat_flags(flags), .o_cmd_strobe(o_cmd_strobe), .o_cmd_word(o_cmd_word),
      .o_cmd_target(o_cmd_target), .o_response_format_select(o_response_format_select));
   sdspi_host u_host (.o_sck(sck), .o_sdi(sdi), .o_chip_select_low_n(csn_n),
      .i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe));
   // xorshift source with a fixed start
   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   // compare and count
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, want, seen);
      end
   endtask
   // verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // expected status word for a format code
   function automatic logic [19:0] resp_word(input logic [1:0] sel);
      case (sel)
         RSEL_MSTEP: return {mstep, MARK_DATA, flags};
         RSEL_LOAD: return {load, MARK_DATA, flags};
         RSEL_LOAD_SCALE: return {load[9:5], scale, MARK_DATA, flags};
         default: return {prot[8], dis, prot[7:0], MARK_PROT, flags};
      endcase
   endfunction
   // register picked by the top bits of a command
   function automatic sdspi_target_e tgt_of(input logic [19:0] w);
      if (!w[ADDR_HI]) return TGT_DRV_CTRL;
      case (w[ADDR_MID:ADDR_LO])
         2'h0: return TGT_CHOP_CFG;
         2'h1: return TGT_ENERGY_CFG;
         2'h2: return TGT_STALL_CFG;
         default: return TGT_DRV_CFG;
      endcase
   endfunction
   // random n-bit frame whose last twenty bits start with a target code
   function automatic logic [63:0] frame(input int n, input logic [2:0] head);
      logic [63:0] d;
      d = {rnd(), rnd()} & ((64'h1 << n) - 64'h1);
      d[19:17] = head;
      return d;
   endfunction
   // one transfer: new status, note the command, compare the answer stream
   task automatic send(input int n, input logic [63:0] data, input logic takes);
      logic [63:0] got;
      logic [63:0] want;
      @(posedge i_core_clk);
      #1;
      mstep = 10'(rnd());
      load = 10'(rnd());
      scale = 5'(rnd());
      prot = 9'(rnd());
      flags = 8'(rnd());
      want = ({44'h0, resp_word(cur_sel)} << (n - 20)) | (data >> 20);
      if (takes) begin
         exp_q.push_back(data[19:0]);
      end
      u_host.xfer(n, data, got);
      if (n >= 20) begin
         check("answer stream", got, want);
      end
      for (int i = 0; i < 40 && exp_q.size() != 0; i++) @(posedge i_core_clk);
      if (exp_q.size() != 0) begin
         check("command strobe", exp_q.size(), 0);
         tally_and_finish();
      end
      repeat (2) @(posedge i_core_clk);
      #1;
      if (takes) begin
         last_w = data[19:0];
         if (tgt_of(last_w) == TGT_DRV_CFG) cur_sel = last_w[RSEL_HI:RSEL_LO];
      end
      check("format select", o_response_format_select, cur_sel);
      check("held command", o_cmd_word, last_w);
   endtask
   // each strobe takes the oldest awaited command, looked at mid-cycle
   always @(negedge i_core_clk) begin
      if (o_cmd_strobe === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("unexpected strobe", 64'h1, 64'h0);
         end else begin
            mon_w = exp_q.pop_front();
            check("command word", o_cmd_word, mon_w);
            check("command target", o_cmd_target, tgt_of(mon_w));
         end
      end
   end
   // hang guard
   initial begin
      #5000000;
      err_count++;
      $display("Error run time expected done seen running");
      tally_and_finish();
   end
   // main sequence
   initial begin
      i_nrst = 1'b0;
      dis = 1'b0;
      {mstep, load, scale, prot, flags} = '0;
      cur_sel = RSEL_RST;
      last_w = WORD_RST;
      repeat (10) @(posedge i_core_clk);
      #1;
      i_nrst = 1'b1;
      check("reset word", o_cmd_word, WORD_RST);
      check("reset strobe", o_cmd_strobe, 1'b0);
      check("reset enable", o_sdo_oe, 1'b0);
      $display("test reset done");
      // disable pin passes, a short dip does not
      dis = 1'b1;
      repeat (10) @(posedge i_core_clk);
      check("disable level", o_driver_disable, 1'b1);
      #95;
      dis = 1'b0;
      #15;
      dis = 1'b1;
      repeat (10) @(posedge i_core_clk);
      check("disable glitch", o_driver_disable, 1'b1);
      $display("test disable done");
      // configuration first, every response format in turn
      for (int s = 0; s < 5; s++) begin
         cfg = frame(20, 3'h7);
         cfg[RSEL_HI:RSEL_LO] = 2'(s);
         send(20, cfg, 1'b1);
      end
      $display("test formats done");
      // padded and chained frames to every register
      for (int i = 0; i < 5; i++) begin
         send(20 + 4 * i + (i / 4) * 4, frame(20 + 4 * i + (i / 4) * 4, 3'(i + 3)), 1'b1);
      end
      $display("test targets done");
      // short frame leaves the command alone
      send(12, frame(12, 3'h4) & 64'hFFF, 1'b0);
      $display("test short done");
      u_host.noise(25);
      @(posedge i_core_clk);
      #95;
      u_host.csn_glitch();
      repeat (20) @(posedge i_core_clk);
      check("idle enable", o_sdo_oe, 1'b0);
      check("idle command", o_cmd_word, last_w);
      check("enable in frame", u_host.oe_miss, 0);
      check("pending commands", exp_q.size(), 0);
      $display("test deselected done");
      tally_and_finish();
   end
endmodule
